// ==== design/dio_pkg.sv ====
// Package with constants and types for the direct I/O mapping and latch reset block
package dio_pkg;
   // Point counts and widths
   localparam int unsigned NUM_POINTS = 32;
   localparam int unsigned NODE_W     = 4;
   localparam int unsigned BIT_W      = 5;
   localparam int unsigned OPND_W     = 8;
   localparam int unsigned NUM_NODES  = 16;
   localparam int unsigned NUM_LATCH  = 16;

   // Fallback setting encodings
   typedef enum logic [1:0] {
      DIO_FB_ON          = 2'h0,
      DIO_FB_OFF         = 2'h1,
      DIO_FB_LATEST_ON   = 2'h2,
      DIO_FB_LATEST_OFF  = 2'h3
   } dio_fallback_t;

   // Reset source state machine
   typedef enum logic [1:0] {
      DIO_RS_IDLE  = 2'h0,
      DIO_RS_PULSE = 2'h1
   } dio_rst_state_t;

   // Timing defaults in clock cycles (200 MHz)
   localparam int unsigned CLK_PERIOD_NS     = 5;
   localparam int unsigned TIMEOUT_NS        = 100_000;
   localparam int unsigned TIMEOUT_CYC       = TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int unsigned RESEND_NS         = 1_000_000;
   localparam int unsigned RESEND_CYC        = RESEND_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W             = 24;

   // Reset values
   localparam logic [NUM_POINTS-1:0] POINTS_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0]      CNT_ZERO   = 24'h00_0000;
endpackage

// ==== design/dio_node_watch.sv ====
// Per-node online watchdog for peer messages
`timescale 1ns/1ps
module dio_node_watch
   import dio_pkg::*;
#(
   parameter int unsigned NODES = NUM_NODES
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   // Message arrival
   input  wire logic                msg_valid_i,
   input  wire logic [NODE_W-1:0]   msg_node_i,
   input  wire logic [CNT_W-1:0]    timeout_cyc_i,
   // Node status
   output logic [NODES-1:0]         online_o
);
   logic [CNT_W-1:0] age [NODES];

   // Age counters: reload on valid message, expire to offline
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int n = 0; n < NODES; n++) begin
            age[n] <= CNT_ZERO;
         end
         online_o <= '0;
      end else begin
         for (int n = 0; n < NODES; n++) begin
            if (msg_valid_i && (msg_node_i == NODE_W'(n))) begin
               age[n]      <= CNT_ZERO;
               online_o[n] <= 1'b1;
            end else if (online_o[n]) begin
               if (age[n] >= timeout_cyc_i) begin
                  online_o[n] <= 1'b0;
               end else begin
                  age[n] <= age[n] + CNT_W'(1);
               end
            end
         end
      end
   end
endmodule

// ==== design/dio_status_tx.sv ====
// Status message builder with change or interval triggered resend
`timescale 1ns/1ps
module dio_status_tx
   import dio_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_b_i,
   // Selected points and interval
   input  wire logic [NUM_POINTS-1:0]  points_i,
   input  wire logic [CNT_W-1:0]       interval_cyc_i,
   // Outgoing message
   output logic [NUM_POINTS-1:0]       status_o,
   output logic                        send_o
);
   logic [CNT_W-1:0] timer;
   logic             changed;

   assign changed = (points_i != status_o);

   // Send on change, else resend after interval
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer    <= CNT_ZERO;
         status_o <= POINTS_RST;
         send_o   <= 1'b0;
      end else begin
         status_o <= points_i;
         if (changed || (timer >= interval_cyc_i)) begin
            timer  <= CNT_ZERO;
            send_o <= 1'b1;
         end else begin
            timer  <= timer + CNT_W'(1);
            send_o <= 1'b0;
         end
      end
   end
endmodule

// ==== design/dio_top.sv ====
// Direct I/O point mapping, fallback handling, status resend and latch reset
// Function
// - 32 received inputs each take a configured bit of a configured peer message.
// - Bit number equals the sending peer's transmitted output index.
// - Offline peer makes input show its per-input fallback value.
// - Forced-high fallback drives input to 1 while peer offline.
// - Forced-low fallback drives input to 0 while peer offline.
// - Hold-last modes freeze input at last received value on link loss.
// - Nothing received yet: hold-last-high gives 1, hold-last-low gives 0.
// - On link recovery input follows live data again in all modes.
// - 32 transmitted outputs carry their selected internal operand.
// - 32 status points carry their individually selected operand.
// - Status message resent at configured interval when nothing changed.
// - Latches stay set after condition clears until a reset command.
// - Reset command comes from button, link channel, or internal operand.
// - Reset clears a latch only if its condition cleared.
// - Every reset raises common event plus a source specific event.
// - Reset events are recorded in the event log.
// - Selector picks which internal operand generates the operand reset.
`timescale 1ns/1ps
module dio_top
   import dio_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int unsigned RESEND_CYCLES  = RESEND_CYC
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   // Received peer messages
   input  wire logic                         rx_msg_valid_i,
   input  wire logic [NODE_W-1:0]            rx_msg_node_i,
   input  wire logic [NUM_POINTS-1:0]        rx_msg_bits_i,
   // Received point configuration
   input  wire logic [NUM_POINTS*NODE_W-1:0] rx_point_source_node_i,
   input  wire logic [NUM_POINTS*BIT_W-1:0]  rx_point_bit_i,
   input  wire logic [NUM_POINTS*2-1:0]      rx_point_fallback_i,
   // Internal operands and selectors
   input  wire logic [(1<<OPND_W)-1:0]       operands_i,
   input  wire logic [NUM_POINTS*OPND_W-1:0] tx_point_sel_i,
   input  wire logic [NUM_POINTS*OPND_W-1:0] user_status_sel_i,
   input  wire logic [OPND_W-1:0]            reset_operand_sel_i,
   // Reset command sources
   input  wire logic                         reset_button_i,
   input  wire logic                         reset_link_i,
   // Latch conditions
   input  wire logic [NUM_LATCH-1:0]         latch_cond_i,
   // Received and transmitted points
   output logic [NUM_POINTS-1:0]             rx_point_o,
   output logic [NUM_NODES-1:0]              node_online_o,
   output logic [NUM_POINTS-1:0]             tx_point_o,
   output logic [NUM_POINTS-1:0]             user_status_point_o,
   output logic                              status_send_o,
   // Latches and reset events
   output logic [NUM_LATCH-1:0]              latch_o,
   output logic                              reset_event_any_o,
   output logic                              reset_event_button_o,
   output logic                              reset_event_link_o,
   output logic                              reset_event_internal_o,
   output logic                              event_log_valid_o,
   output logic [3:0]                        event_log_code_o
);
   // Operand selector shared by every mapping
   function automatic logic pick(input logic [(1<<OPND_W)-1:0] ops,
                                 input logic [OPND_W-1:0]      sel);
      pick = ops[sel];
   endfunction

   localparam logic [CNT_W-1:0] TMO_CNT = CNT_W'(TIMEOUT_CYCLES);
   localparam logic [CNT_W-1:0] RSD_CNT = CNT_W'(RESEND_CYCLES);

   logic [NUM_NODES-1:0]  online;
   logic [NUM_POINTS-1:0] last_val;
   logic [NUM_POINTS-1:0] have_val;
   logic [NUM_POINTS-1:0] next_rx;
   logic [NUM_POINTS-1:0] status_pts;
   logic [NUM_POINTS-1:0] next_user;

   // Synchronisers for pin level reset sources
   logic [1:0] btn_sync;
   logic [1:0] lnk_sync;
   logic       btn_prev;
   logic       lnk_prev;
   logic       opnd_prev;
   logic       btn_rise;
   logic       lnk_rise;
   logic       opnd_rise;
   logic       opnd_now;
   dio_rst_state_t rst_state;

   // Node watchdog
   dio_node_watch #(
      .NODES (NUM_NODES)
   ) u_watch (
      .clk_i         (clk_i),
      .rst_b_i       (rst_b_i),
      .msg_valid_i   (rx_msg_valid_i),
      .msg_node_i    (rx_msg_node_i),
      .timeout_cyc_i (TMO_CNT),
      .online_o      (online)
   );

   // Hold-last storage: last value seen per input while its node sends
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_val <= POINTS_RST;
         have_val <= POINTS_RST;
      end else begin
         for (int i = 0; i < NUM_POINTS; i++) begin
            if (rx_msg_valid_i &&
                rx_msg_node_i == rx_point_source_node_i[i*NODE_W +: NODE_W]) begin
               last_val[i] <= rx_msg_bits_i[rx_point_bit_i[i*BIT_W +: BIT_W]];
               have_val[i] <= 1'b1;
            end
         end
      end
   end

   // Received point value with fallback selection
   always_comb begin
      next_rx = POINTS_RST;
      for (int i = 0; i < NUM_POINTS; i++) begin
         if (online[rx_point_source_node_i[i*NODE_W +: NODE_W]] && have_val[i]) begin
            next_rx[i] = last_val[i];
         end else begin
            case (dio_fallback_t'(rx_point_fallback_i[i*2 +: 2]))
               DIO_FB_ON:         next_rx[i] = 1'b1;
               DIO_FB_OFF:        next_rx[i] = 1'b0;
               DIO_FB_LATEST_ON:  next_rx[i] = have_val[i] ? last_val[i] : 1'b1;
               DIO_FB_LATEST_OFF: next_rx[i] = have_val[i] ? last_val[i] : 1'b0;
               default:           next_rx[i] = 1'b0;
            endcase
         end
      end
   end

   // Registered received points and node status
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_point_o    <= POINTS_RST;
         node_online_o <= '0;
      end else begin
         rx_point_o    <= next_rx;
         node_online_o <= online;
      end
   end

   // Transmitted points and status point selection
   always_comb begin
      next_user = POINTS_RST;
      for (int i = 0; i < NUM_POINTS; i++) begin
         next_user[i] = pick(operands_i, user_status_sel_i[i*OPND_W +: OPND_W]);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_point_o <= POINTS_RST;
      end else begin
         for (int i = 0; i < NUM_POINTS; i++) begin
            tx_point_o[i] <= pick(operands_i, tx_point_sel_i[i*OPND_W +: OPND_W]);
         end
      end
   end

   // Status message with periodic resend
   dio_status_tx u_status (
      .clk_i          (clk_i),
      .rst_b_i        (rst_b_i),
      .points_i       (next_user),
      .interval_cyc_i (RSD_CNT),
      .status_o       (status_pts),
      .send_o         (status_send_o)
   );

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         user_status_point_o <= POINTS_RST;
      end else begin
         user_status_point_o <= status_pts;
      end
   end

   // Reset source synchronisers and edge history
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         btn_sync  <= 2'h0;
         lnk_sync  <= 2'h0;
         btn_prev  <= 1'b0;
         lnk_prev  <= 1'b0;
         opnd_prev <= 1'b0;
      end else begin
         btn_sync  <= {btn_sync[0], reset_button_i};
         lnk_sync  <= {lnk_sync[0], reset_link_i};
         btn_prev  <= btn_sync[1];
         lnk_prev  <= lnk_sync[1];
         opnd_prev <= opnd_now;
      end
   end

   assign opnd_now  = pick(operands_i, reset_operand_sel_i);
   assign btn_rise  = btn_sync[1] & ~btn_prev;
   assign lnk_rise  = lnk_sync[1] & ~lnk_prev;
   assign opnd_rise = opnd_now & ~opnd_prev;

   // Reset event pulses, one cycle per command
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_state              <= DIO_RS_IDLE;
         reset_event_any_o      <= 1'b0;
         reset_event_button_o   <= 1'b0;
         reset_event_link_o     <= 1'b0;
         reset_event_internal_o <= 1'b0;
      end else begin
         reset_event_button_o   <= btn_rise;
         reset_event_link_o     <= lnk_rise;
         reset_event_internal_o <= opnd_rise;
         reset_event_any_o      <= btn_rise | lnk_rise | opnd_rise;
         case (rst_state)
            DIO_RS_IDLE:  rst_state <= (btn_rise | lnk_rise | opnd_rise) ?
                                       DIO_RS_PULSE : DIO_RS_IDLE;
            // A command on the very next cycle keeps the log strobe up
            DIO_RS_PULSE: rst_state <= (btn_rise | lnk_rise | opnd_rise) ?
                                       DIO_RS_PULSE : DIO_RS_IDLE;
            default:      rst_state <= DIO_RS_IDLE;
         endcase
      end
   end

   // Event log record: bit0 any, bit1 button, bit2 link, bit3 operand
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         event_log_valid_o <= 1'b0;
         event_log_code_o  <= 4'h0;
      end else begin
         event_log_valid_o <= (rst_state == DIO_RS_PULSE);
         event_log_code_o  <= {reset_event_internal_o, reset_event_link_o,
                               reset_event_button_o, reset_event_any_o};
      end
   end

   // Indicator latches: set wins, clear only when condition gone
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         latch_o <= '0;
      end else begin
         for (int i = 0; i < NUM_LATCH; i++) begin
            if (latch_cond_i[i]) begin
               latch_o[i] <= 1'b1;
            end else if (reset_event_any_o) begin
               latch_o[i] <= 1'b0;
            end
         end
      end
   end
endmodule

// ==== bench/dio_peer_model.sv ====
// Behavioural peer node that sends direct point messages into the block
`timescale 1ns/1ps
module dio_peer_model
   import dio_pkg::*;
(
   // Clock
   input  wire logic                  clk_i,
   // Message towards the block
   output logic                       msg_valid_o,
   output logic [NODE_W-1:0]          msg_node_o,
   output logic [NUM_POINTS-1:0]      msg_bits_o
);
   logic                  pend = 1'b0;
   logic [NODE_W-1:0]     pn   = '0;
   logic [NUM_POINTS-1:0] pb   = '0;
   initial begin
      msg_valid_o = 1'b0;
      msg_node_o  = '0;
      msg_bits_o  = '0;
   end
   // Idle lines flip every cycle so stale data never passes for a message
   always @(posedge clk_i) begin
      msg_valid_o <= pend;
      msg_node_o  <= pend ? pn : ~msg_node_o;
      msg_bits_o  <= pend ? pb : ~msg_bits_o;
      pend        <= 1'b0;
   end
   // Queue one message; bit k carries this peer's transmitted output k
   task automatic send(input logic [NODE_W-1:0] n, input logic [NUM_POINTS-1:0] b);
      @(negedge clk_i);
      pn   = n;
      pb   = b;
      pend = 1'b1;
   endtask
endmodule

// ==== bench/dio_top_chk.sv ====
// Concurrent checks on the ports of the direct I/O block
`timescale 1ns/1ps
module dio_top_chk
   import dio_pkg::*;
(
   // Clock, reset and stimulus
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   input  wire logic                         rx_msg_valid_i,
   input  wire logic [NODE_W-1:0]            rx_msg_node_i,
   input  wire logic [NUM_POINTS*NODE_W-1:0] rx_point_source_node_i,
   input  wire logic [NUM_POINTS*2-1:0]      rx_point_fallback_i,
   input  wire logic [(1<<OPND_W)-1:0]       operands_i,
   input  wire logic [NUM_POINTS*OPND_W-1:0] tx_point_sel_i,
   input  wire logic [NUM_POINTS*OPND_W-1:0] user_status_sel_i,
   input  wire logic [OPND_W-1:0]            reset_operand_sel_i,
   input  wire logic                         reset_button_i,
   input  wire logic [NUM_LATCH-1:0]         latch_cond_i,
   // Observed outputs
   input  wire logic [NUM_POINTS-1:0]        rx_point_o,
   input  wire logic [NUM_NODES-1:0]         node_online_o,
   input  wire logic [NUM_POINTS-1:0]        tx_point_o,
   input  wire logic [NUM_POINTS-1:0]        user_status_point_o,
   input  wire logic [NUM_LATCH-1:0]         latch_o,
   input  wire logic                         reset_event_any_o,
   input  wire logic                         reset_event_button_o,
   input  wire logic                         reset_event_link_o,
   input  wire logic                         reset_event_internal_o,
   input  wire logic                         event_log_valid_o,
   input  wire logic [3:0]                   event_log_code_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Point mapping and fallback
   chk_online_after_msg: assert property (
      rx_msg_valid_i |-> ##2 node_online_o[$past(rx_msg_node_i, 2)])
      else $error("node not online after message");
   chk_fb_forced_high: assert property (
      (!node_online_o[rx_point_source_node_i[3:0]]
       && rx_point_fallback_i[1:0] == DIO_FB_ON)[*4] |-> rx_point_o[0])
      else $error("offline input not forced high");
   chk_fb_forced_low: assert property (
      (!node_online_o[rx_point_source_node_i[7:4]]
       && rx_point_fallback_i[3:2] == DIO_FB_OFF)[*4] |-> !rx_point_o[1])
      else $error("offline input not forced low");
   chk_tx_follow: assert property (
      $past(rst_b_i) |-> tx_point_o[0] == $past(operands_i[tx_point_sel_i[7:0]]))
      else $error("transmitted point wrong");
   chk_status_follow: assert property (
      $past(rst_b_i, 2) |->
      user_status_point_o[31] == $past(operands_i[user_status_sel_i[255:248]], 2))
      else $error("status point wrong");
   // Latches and reset events
   chk_latch_set: assert property (latch_cond_i[0] |=> latch_o[0])
      else $error("latch not set");
   chk_latch_hold: assert property (latch_o[0] && !reset_event_any_o |=> latch_o[0])
      else $error("latch dropped without reset");
   chk_latch_clear: assert property (
      reset_event_any_o && !latch_cond_i[0] |=> !latch_o[0])
      else $error("latch not cleared");
   chk_any_source: assert property (reset_event_any_o ==
      (reset_event_button_o | reset_event_link_o | reset_event_internal_o))
      else $error("common reset event mismatch");
   chk_operand_reset: assert property (
      $rose(operands_i[reset_operand_sel_i]) |=> reset_event_internal_o)
      else $error("operand reset missing");
   chk_button_delay: assert property (
      $rose(reset_button_i) |-> ##[3:5] reset_event_button_o)
      else $error("button reset missing");
   chk_log_code: assert property (reset_event_any_o |=> event_log_valid_o &&
      event_log_code_o == $past({reset_event_internal_o, reset_event_link_o,
                                 reset_event_button_o, reset_event_any_o}))
      else $error("event log wrong");
   cover property (reset_event_link_o);
   cover property (reset_event_internal_o);
   cover property (latch_o[0] ##1 !latch_o[0]);
endmodule
bind dio_top dio_top_chk i_dio_top_chk (.clk_i, .rst_b_i, .rx_msg_valid_i,
   .rx_msg_node_i, .rx_point_source_node_i, .rx_point_fallback_i, .operands_i,
   .tx_point_sel_i, .user_status_sel_i, .reset_operand_sel_i, .reset_button_i,
   .latch_cond_i, .rx_point_o, .node_online_o, .tx_point_o, .user_status_point_o,
   .latch_o, .reset_event_any_o, .reset_event_button_o, .reset_event_link_o,
   .reset_event_internal_o, .event_log_valid_o, .event_log_code_o);

// ==== bench/dio_top_tb.sv ====
// Self-checking testbench for the direct I/O mapping and latch reset block
`timescale 1ns/1ps
module dio_top_tb
   import dio_pkg::*;
;
   localparam int unsigned TO = 20;
   localparam int unsigned RS = 30;
   logic clk_i = 1'b0, rst_b_i = 1'b0, rx_msg_valid_i;
   logic [3:0] rx_msg_node_i, event_log_code_o;
   logic [31:0] rx_msg_bits_i, rx_point_o, tx_point_o, user_status_point_o;
   logic [127:0] rx_point_source_node_i = '0;
   logic [159:0] rx_point_bit_i = '0;
   logic [63:0] rx_point_fallback_i = '0;
   logic [255:0] operands_i = '0, tx_point_sel_i = '0, user_status_sel_i = '0;
   logic [7:0] reset_operand_sel_i = '0;
   logic reset_button_i = 1'b0, reset_link_i = 1'b0, status_send_o, event_log_valid_o;
   logic [15:0] latch_cond_i = '0, node_online_o, latch_o;
   logic reset_event_any_o, reset_event_button_o, reset_event_link_o, reset_event_internal_o;
   int mismatches = 0, checks = 0, cyc = 0;
   dio_top #(.TIMEOUT_CYCLES(TO), .RESEND_CYCLES(RS)) i_dio_top (.clk_i, .rst_b_i,
      .rx_msg_valid_i, .rx_msg_node_i, .rx_msg_bits_i, .rx_point_source_node_i,
      .rx_point_bit_i, .rx_point_fallback_i, .operands_i, .tx_point_sel_i,
      .user_status_sel_i, .reset_operand_sel_i, .reset_button_i, .reset_link_i,
      .latch_cond_i, .rx_point_o, .node_online_o, .tx_point_o, .user_status_point_o,
      .status_send_o, .latch_o, .reset_event_any_o, .reset_event_button_o,
      .reset_event_link_o, .reset_event_internal_o, .event_log_valid_o, .event_log_code_o);
   dio_peer_model i_dio_peer_model (.clk_i, .msg_valid_o(rx_msg_valid_i),
      .msg_node_o(rx_msg_node_i), .msg_bits_o(rx_msg_bits_i));
   initial forever #2.5 clk_i = ~clk_i;
   // Cut a hang short
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize();
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Inputs 0..3 read nodes 2,3,2,3 in all four fallback modes
   task automatic t_rx_cfg();
      @(posedge clk_i);
      rx_point_source_node_i[15:0] <= 16'h3232;
      rx_point_bit_i[19:0] <= {5'h07, 5'h05, 5'h03, 5'h0C};
      rx_point_fallback_i[7:0] <= {DIO_FB_LATEST_OFF, DIO_FB_LATEST_ON, DIO_FB_OFF, DIO_FB_ON};
      tick(4);
      cmp(rx_point_o & 32'hF, 32'h5);
   endtask
   task automatic t_rx_live();
      i_dio_peer_model.send(4'h5, 32'hFFFF_FFFF);
      i_dio_peer_model.send(4'h2, 32'hFFFF_EFDF);
      i_dio_peer_model.send(4'h3, 32'h0000_0088);
      tick(4);
      cmp(rx_point_o & 32'hF, 32'hA);
      cmp({16'h0, node_online_o}, 32'h2C);
      tick(TO + 4);
      cmp({16'h0, node_online_o}, 32'h0);
      cmp(rx_point_o & 32'hF, 32'h9);
      i_dio_peer_model.send(4'h2, 32'h0000_0020);
      i_dio_peer_model.send(4'h3, 32'h0000_0008);
      tick(4);
      cmp(rx_point_o & 32'hF, 32'h6);
   endtask
   task automatic t_tx_map();
      logic [255:0] ts, us, pat = {8{32'h9C5A_36E1}};
      logic [31:0] et, eu;
      for (int i = 0; i < 32; i++) begin
         ts[i*8+:8] = 8'(i * 7 + 1);
         us[i*8+:8] = 8'(255 - i * 3);
         et[i] = pat[i*7+1];
         eu[i] = pat[255-i*3];
      end
      @(posedge clk_i);
      tx_point_sel_i <= ts;
      user_status_sel_i <= us;
      operands_i <= pat;
      tick(3);
      cmp(tx_point_o, et);
      cmp(user_status_point_o, eu);
      @(posedge clk_i);
      operands_i <= ~pat;
      tick(3);
      cmp(tx_point_o, ~et);
      cmp(user_status_point_o, ~eu);
   endtask
   // Quiet operands: the message repeats at the set interval
   task automatic t_resend();
      int n;
      for (n = 0; n < 100 && status_send_o !== 1'b1; n++) tick(1);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (status_send_o !== 1'b1 && n < 100);
      cmp(32'(n), 32'(RS + 1));
   endtask
   task automatic reset_from(input int k);
      int n;
      @(posedge clk_i);
      if (k == 0) reset_button_i <= 1'b1;
      else if (k == 1) reset_link_i <= 1'b1;
      else operands_i[200] <= 1'b1;
      for (n = 0; n < 10 && reset_event_any_o !== 1'b1; n++) tick(1);
      cmp({29'h0, reset_event_internal_o, reset_event_link_o, reset_event_button_o},
          32'h1 << k);
      tick(1);
      cmp({27'h0, event_log_valid_o, event_log_code_o}, 32'h11 | (32'h2 << k));
      @(posedge clk_i);
      reset_button_i <= 1'b0;
      reset_link_i <= 1'b0;
      operands_i[200] <= 1'b0;
      tick(6);
   endtask
   // Latch 0 condition clears, latch 1 condition stays high
   task automatic t_latch();
      @(posedge clk_i);
      latch_cond_i <= 16'h0003;
      operands_i <= '0;
      reset_operand_sel_i <= 8'hC8;
      tick(2);
      @(posedge clk_i);
      latch_cond_i <= 16'h0002;
      tick(3);
      cmp({16'h0, latch_o}, 32'h3);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i);
         latch_cond_i <= 16'h0003;
         @(posedge clk_i);
         latch_cond_i <= 16'h0002;
         tick(2);
         cmp({16'h0, latch_o}, 32'h3);
         reset_from(k);
         cmp({16'h0, latch_o}, 32'h2);
      end
      // Button then operand command one cycle apart: the operand record follows with the log strobe still up
      @(posedge clk_i);
      reset_button_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      operands_i[200] <= 1'b1;
      tick(2);
      cmp({27'h0, event_log_valid_o, event_log_code_o}, 32'h19);
      @(posedge clk_i);
      reset_button_i <= 1'b0;
      operands_i[200] <= 1'b0;
      tick(6);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      tick(1);
      t_rx_cfg();
      t_rx_live();
      t_tx_map();
      t_resend();
      t_latch();
      summarize();
   end
endmodule
